/* File: core/osg_core.v */
// Purpose: operation status group with AXI4-Lite register access
// Assumes: cond_in synchronous to aclk, synchronous active-low reset
// Notes:   one write and one read under way at a time
`timescale 1ns/1ps
`include "osg_defs.vh"

// How it works
// - condition register is read-only, shows live status, read has no effect
// - condition bits follow their inputs and clear when the condition leaves
// - instrument reset clears condition bits except those still present
// - a read returns the register bits as one unsigned binary-weighted value
// - enable register is read/write and masks events onto the summary bit
// - status preset clears the whole enable register
// - enable and filter registers written as binary-weighted value, reset zero
// - clear-status clears event register, enable register untouched
// - negative filter bit set: falling condition bit sets event bit
// - positive filter bit set: rising condition bit sets event bit
// - status preset sets all positive filter bits, clears negative filter
// - both filter bits set: either change sets the event bit
// - both filter bits clear: no change can set the event bit
// - both filters writable and readable, placed between condition and event
// - event register read-only, latches filtered transitions, cleared by read
// - instrument reset leaves event register alone except captured transitions
module osg_core (
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire [`OSG_AW-1:0]    s_axi_awaddr,
    input  wire [2:0]            s_axi_awprot,
    input  wire                  s_axi_awvalid,
    output wire                  s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output wire                  s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [`OSG_AW-1:0]    s_axi_araddr,
    input  wire [2:0]            s_axi_arprot,
    input  wire                  s_axi_arvalid,
    output wire                  s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    input  wire [`OSG_WIDTH-1:0] cond_in,
    output reg                   inst_reset,
    output wire                  oper_summary,
    output wire                  irq
);

    localparam W = `OSG_WIDTH;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function [3:0] reg_sel;
        input [`OSG_AW-1:0] addr;
        begin
            case (addr)
                `OSG_ADDR_COND:    reg_sel = `OSG_SEL_COND;
                `OSG_ADDR_EVENT:   reg_sel = `OSG_SEL_EVENT;
                `OSG_ADDR_ENABLE:  reg_sel = `OSG_SEL_ENABLE;
                `OSG_ADDR_PTR:     reg_sel = `OSG_SEL_PTR;
                `OSG_ADDR_NTR:     reg_sel = `OSG_SEL_NTR;
                `OSG_ADDR_CMD:     reg_sel = `OSG_SEL_CMD;
                `OSG_ADDR_IRQ_ST:  reg_sel = `OSG_SEL_IRQ_ST;
                `OSG_ADDR_IRQ_MSK: reg_sel = `OSG_SEL_IRQ_MSK;
                default:           reg_sel = `OSG_SEL_NONE;
            endcase
        end
    endfunction

    function [W-1:0] merge16;
        input [W-1:0] old;
        input [31:0]  data;
        input [3:0]   strb;
        begin
            merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    function cmd_bit;
        input [3:0] strb;
        input       bit_val;
        begin
            cmd_bit = strb[0] && bit_val;
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [W-1:0]              cond;
    reg  [W-1:0]              event_reg;
    reg  [W-1:0]              enable;
    reg  [W-1:0]              ptr;
    reg  [W-1:0]              ntr;
    reg  [`OSG_IRQ_WIDTH-1:0] irq_status;
    reg  [`OSG_IRQ_WIDTH-1:0] irq_mask;
    reg                       summary_q;

    reg                       aw_held;
    reg  [`OSG_AW-1:0]        aw_addr;
    reg                       w_held;
    reg  [31:0]               w_data;
    reg  [3:0]                w_strb;

    wire [W-1:0]              evt_set;
    wire [W-1:0]              next_event;
    wire [`OSG_IRQ_WIDTH-1:0] irq_set;
    wire [`OSG_IRQ_WIDTH-1:0] next_irq_status;
    wire                      wr_fire;
    wire                      rd_fire;
    wire [3:0]                wr_sel;
    wire [3:0]                rd_sel;
    wire                      cmd_rst;
    wire                      cmd_cls;
    wire                      cmd_pre;
    wire                      rd_clr_event;
    wire                      rd_clr_irq;
    reg  [31:0]               next_rdata;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_sel        = reg_sel(aw_addr);
    assign rd_sel        = reg_sel(s_axi_araddr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= {`OSG_AW{1'b0}};
            w_held  <= 1'b0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `OSG_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == `OSG_SEL_NONE) ? `OSG_RESP_SLVERR : `OSG_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    wire                      wr_en_cmd;
    wire                      wr_en_enable;
    wire                      wr_en_ptr;
    wire                      wr_en_ntr;
    wire                      wr_en_irq_msk;

    assign wr_en_cmd     = wr_fire && (wr_sel == `OSG_SEL_CMD);
    assign wr_en_enable  = wr_fire && (wr_sel == `OSG_SEL_ENABLE);
    assign wr_en_ptr     = wr_fire && (wr_sel == `OSG_SEL_PTR);
    assign wr_en_ntr     = wr_fire && (wr_sel == `OSG_SEL_NTR);
    assign wr_en_irq_msk = wr_fire && (wr_sel == `OSG_SEL_IRQ_MSK) && w_strb[0];

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    assign cmd_rst = wr_en_cmd && cmd_bit(w_strb, w_data[`OSG_CMD_RST_BIT]);
    assign cmd_cls = wr_en_cmd && cmd_bit(w_strb, w_data[`OSG_CMD_CLS_BIT]);
    assign cmd_pre = wr_en_cmd && cmd_bit(w_strb, w_data[`OSG_CMD_PRE_BIT]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            inst_reset <= 1'b0;
        end else begin
            inst_reset <= cmd_rst;
        end
    end

    // ----------------------------------------------------------------
    // condition register
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            cond <= `OSG_ZERO16;
        end else if (cmd_rst) begin
            cond <= cond_in;
        end else begin
            cond <= cond_in;
        end
    end

    // ----------------------------------------------------------------
    // transition filters
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_filter
            wire rise = cond_in[i] & ~cond[i];
            wire fall = ~cond_in[i] & cond[i];
            assign evt_set[i] = (ptr[i] & rise) | (ntr[i] & fall);
        end
    endgenerate

    // ----------------------------------------------------------------
    // event register
    // ----------------------------------------------------------------
    assign rd_clr_event = rd_fire && (rd_sel == `OSG_SEL_EVENT);
    assign next_event   = ((rd_clr_event || cmd_cls) ? `OSG_ZERO16 : event_reg) | evt_set;

    always @(posedge aclk) begin
        if (!aresetn) begin
            event_reg <= `OSG_ZERO16;
        end else begin
            event_reg <= next_event;
        end
    end

    // ----------------------------------------------------------------
    // enable and filter registers
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            enable <= `OSG_ENABLE_RST;
            ptr    <= `OSG_PTR_RST;
            ntr    <= `OSG_NTR_RST;
        end else if (cmd_pre) begin
            enable <= `OSG_ENABLE_PRE;
            ptr    <= `OSG_PTR_PRESET;
            ntr    <= `OSG_NTR_PRESET;
        end else begin
            if (wr_en_enable) begin
                enable <= merge16(enable, w_data, w_strb);
            end
            if (wr_en_ptr) begin
                ptr <= merge16(ptr, w_data, w_strb);
            end
            if (wr_en_ntr) begin
                ntr <= merge16(ntr, w_data, w_strb);
            end
        end
    end

    // ----------------------------------------------------------------
    // summary bit
    // ----------------------------------------------------------------
    osg_summary u_summary (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .event_bits  (event_reg),
        .enable_bits (enable),
        .summary     (oper_summary)
    );

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    assign irq_set[`OSG_IRQ_EVT_BIT] = |evt_set;
    assign irq_set[`OSG_IRQ_SUM_BIT] = oper_summary & ~summary_q;
    assign rd_clr_irq      = rd_fire && (rd_sel == `OSG_SEL_IRQ_ST);
    assign next_irq_status = (rd_clr_irq ? `OSG_IRQ_RST : irq_status) | irq_set;
    assign irq             = |(irq_status & irq_mask);

    always @(posedge aclk) begin
        if (!aresetn) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= oper_summary;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= `OSG_IRQ_RST;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= `OSG_IRQ_RST;
        end else if (wr_en_irq_msk) begin
            irq_mask <= w_data[`OSG_IRQ_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 32'h00000000;
        case (rd_sel)
            `OSG_SEL_COND:    next_rdata = {16'h0000, cond};
            `OSG_SEL_EVENT:   next_rdata = {16'h0000, event_reg};
            `OSG_SEL_ENABLE:  next_rdata = {16'h0000, enable};
            `OSG_SEL_PTR:     next_rdata = {16'h0000, ptr};
            `OSG_SEL_NTR:     next_rdata = {16'h0000, ntr};
            `OSG_SEL_CMD:     next_rdata = 32'h00000000;
            `OSG_SEL_IRQ_ST:  next_rdata = {30'h00000000, irq_status};
            `OSG_SEL_IRQ_MSK: next_rdata = {30'h00000000, irq_mask};
            default:          next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `OSG_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= (rd_sel == `OSG_SEL_NONE) ? `OSG_RESP_SLVERR : `OSG_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // osg_core

/* File: core/osg_summary.v */
// Purpose: operation summary bit from event and enable
// Assumes: one clock, synchronous active-low reset
// Notes:   summary is registered
`timescale 1ns/1ps
`include "osg_defs.vh"

module osg_summary (
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire [`OSG_WIDTH-1:0] event_bits,
    input  wire [`OSG_WIDTH-1:0] enable_bits,
    output reg                   summary
);

    // ----------------------------------------------------------------
    // masked reduction
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            summary <= 1'b0;
        end else begin
            summary <= |(event_bits & enable_bits);
        end
    end

endmodule // osg_summary

/* File: pkg/osg_defs.vh */
// Purpose: constants of the operation status group
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes:   definitions only
`ifndef OSG_DEFS_VH
`define OSG_DEFS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define OSG_WIDTH        16
`define OSG_AW           8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OSG_ADDR_COND    8'h00
`define OSG_ADDR_EVENT   8'h04
`define OSG_ADDR_ENABLE  8'h08
`define OSG_ADDR_PTR     8'h0c
`define OSG_ADDR_NTR     8'h10
`define OSG_ADDR_CMD     8'h14
`define OSG_ADDR_IRQ_ST  8'h18
`define OSG_ADDR_IRQ_MSK 8'h1c

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define OSG_SEL_NONE     4'h0
`define OSG_SEL_COND     4'h1
`define OSG_SEL_EVENT    4'h2
`define OSG_SEL_ENABLE   4'h3
`define OSG_SEL_PTR      4'h4
`define OSG_SEL_NTR      4'h5
`define OSG_SEL_CMD      4'h6
`define OSG_SEL_IRQ_ST   4'h7
`define OSG_SEL_IRQ_MSK  4'h8

// ----------------------------------------------------------------
// command bits
// ----------------------------------------------------------------
`define OSG_CMD_RST_BIT  0
`define OSG_CMD_CLS_BIT  1
`define OSG_CMD_PRE_BIT  2

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define OSG_IRQ_EVT_BIT  0
`define OSG_IRQ_SUM_BIT  1
`define OSG_IRQ_WIDTH    2

// ----------------------------------------------------------------
// reset and preset values
// ----------------------------------------------------------------
`define OSG_ENABLE_RST   16'h0000
`define OSG_PTR_RST      16'h0000
`define OSG_NTR_RST      16'h0000
`define OSG_PTR_PRESET   16'hffff
`define OSG_NTR_PRESET   16'h0000
`define OSG_ENABLE_PRE   16'h0000
`define OSG_ZERO16       16'h0000
`define OSG_IRQ_RST      2'h0

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define OSG_RESP_OKAY    2'h0
`define OSG_RESP_SLVERR  2'h2

`endif

/* File: tb/operation_status_group_bench.sv */
// Purpose: self-checking bench of osg_core
// Assumes: AXI4-Lite master driven at rising edges
// Notes:   random values from a fixed seed
`timescale 1ns/1ps
`include "osg_defs.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin n_mismatch = n_mismatch + 1; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module operation_status_group_bench;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00;
    reg  [7:0]  s_axi_araddr = 8'h00;
    reg  [2:0]  s_axi_awprot = 3'h0;
    reg  [2:0]  s_axi_arprot = 3'h0;
    reg         s_axi_awvalid = 1'b0;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hf;
    reg  [15:0] cond_in = 16'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        inst_reset, oper_summary, irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     n_mismatch = 0, n_compared = 0, i, k;
    reg  [31:0] rv;
    reg  [1:0]  rr;
    reg  [15:0] p, n, c1, e;
    reg         sa, sw, sb;

    always #2.5 aclk = ~aclk;

    osg_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cond_in, .inst_reset, .oper_summary, .irq);
    // ----
    // bus tasks
    // ----
    task close_out;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task hang;
        begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    endtask
    task wr(input [7:0] a, input [15:0] d, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {16'h0000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            for (k = 0; k < 40; k = k + 1) begin
                @(negedge aclk);
                sa = s_axi_awvalid && s_axi_awready;
                sw = s_axi_wvalid && s_axi_wready;
                sb = s_axi_bvalid;
                rr = s_axi_bresp;
                @(posedge aclk);
                if (sa) s_axi_awvalid <= 1'b0;
                if (sw) s_axi_wvalid <= 1'b0;
                if (sb && s_axi_bready) begin
                    s_axi_bready <= 1'b0;
                    k = 99;
                end else if (sb) begin
                    s_axi_bready <= 1'b1;
                end
            end
            if (k != 100) hang;
            `CHK(rr, er)
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            for (k = 0; k < 40; k = k + 1) begin
                @(negedge aclk);
                sa = s_axi_arvalid && s_axi_arready;
                sb = s_axi_rvalid;
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                @(posedge aclk);
                if (sa) s_axi_arvalid <= 1'b0;
                if (sb && s_axi_rready) begin
                    s_axi_rready <= 1'b0;
                    k = 99;
                end else if (sb) begin
                    s_axi_rready <= 1'b1;
                end
            end
            if (k != 100) hang;
        end
    endtask
    task rchk(input [7:0] a, input [15:0] x);
        begin
            rd(a);
            `CHK({rr, rv}, {`OSG_RESP_OKAY, 16'h0000, x})
        end
    endtask
    function [15:0] ev_exp(input [15:0] pt, input [15:0] nt, input [15:0] o, input [15:0] c);
        ev_exp = (pt & c & ~o) | (nt & ~c & o);
    endfunction
    // ----
    // main sequence
    // ----
    initial begin
        i = $urandom(32'hd559c0ad);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OSG_ADDR_ENABLE, `OSG_ENABLE_RST);
        rchk(`OSG_ADDR_PTR, `OSG_PTR_RST);
        rchk(`OSG_ADDR_NTR, `OSG_NTR_RST);
        rchk(`OSG_ADDR_EVENT, 16'h0000);
        wr(`OSG_ADDR_COND, 16'hffff, `OSG_RESP_OKAY);
        rchk(`OSG_ADDR_COND, 16'h0000);
        wr(8'h40, 16'h1234, `OSG_RESP_SLVERR);
        rd(8'h40);
        `CHK({rr, rv}, {`OSG_RESP_SLVERR, 32'h0})
        $display("test reset done");
        for (i = 0; i < 12; i = i + 1) begin
            p = (i == 0) ? 16'hffff : (i == 1) ? 16'h0001 : 16'($urandom);
            wr(`OSG_ADDR_ENABLE + 8'(4 * (i % 3)), p, `OSG_RESP_OKAY);
            rchk(`OSG_ADDR_ENABLE + 8'(4 * (i % 3)), p);
        end
        $display("test read-write done");
        for (i = 0; i < 24; i = i + 1) begin
            p = (i < 4) ? {16{i[0]}} : 16'($urandom);
            n = (i < 4) ? {16{i[1]}} : 16'($urandom);
            wr(`OSG_ADDR_PTR, p, `OSG_RESP_OKAY);
            wr(`OSG_ADDR_NTR, n, `OSG_RESP_OKAY);
            rd(`OSG_ADDR_EVENT);
            c1 = 16'($urandom);
            e = ev_exp(p, n, cond_in, c1);
            @(posedge aclk);
            cond_in <= c1;
            repeat (2) @(posedge aclk);
            rchk(`OSG_ADDR_EVENT, e);
            rchk(`OSG_ADDR_EVENT, 16'h0000);
            rchk(`OSG_ADDR_COND, c1);
        end
        $display("test filters done");
        wr(`OSG_ADDR_ENABLE, 16'h0010, `OSG_RESP_OKAY);
        wr(`OSG_ADDR_PTR, 16'h0010, `OSG_RESP_OKAY);
        wr(`OSG_ADDR_NTR, 16'h0000, `OSG_RESP_OKAY);
        @(posedge aclk);
        cond_in <= 16'h0000;
        repeat (2) @(posedge aclk);
        rd(`OSG_ADDR_EVENT);
        rd(`OSG_ADDR_IRQ_ST);
        wr(`OSG_ADDR_IRQ_MSK, 16'h0003, `OSG_RESP_OKAY);
        @(posedge aclk);
        cond_in <= 16'h0010;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(oper_summary, 1'b1)
        `CHK(irq, 1'b1)
        rchk(`OSG_ADDR_IRQ_ST, 16'h0003);
        @(negedge aclk);
        `CHK(irq, 1'b0)
        wr(`OSG_ADDR_ENABLE, 16'h0000, `OSG_RESP_OKAY);
        repeat (2) @(negedge aclk);
        `CHK(oper_summary, 1'b0)
        wr(`OSG_ADDR_ENABLE, 16'h0010, `OSG_RESP_OKAY);
        repeat (2) @(negedge aclk);
        `CHK(oper_summary, 1'b1)
        wr(`OSG_ADDR_CMD, 16'h0002, `OSG_RESP_OKAY);
        repeat (2) @(negedge aclk);
        `CHK(oper_summary, 1'b0)
        rchk(`OSG_ADDR_ENABLE, 16'h0010);
        rchk(`OSG_ADDR_EVENT, 16'h0000);
        $display("test summary done");
        wr(`OSG_ADDR_NTR, 16'h0010, `OSG_RESP_OKAY);
        @(posedge aclk);
        cond_in <= 16'h0003;
        wr(`OSG_ADDR_CMD, 16'h0001, `OSG_RESP_OKAY);
        rchk(`OSG_ADDR_EVENT, 16'h0010);
        rchk(`OSG_ADDR_COND, 16'h0003);
        wr(`OSG_ADDR_CMD, 16'h0004, `OSG_RESP_OKAY);
        rchk(`OSG_ADDR_ENABLE, `OSG_ENABLE_PRE);
        rchk(`OSG_ADDR_PTR, `OSG_PTR_PRESET);
        rchk(`OSG_ADDR_NTR, `OSG_NTR_PRESET);
        rchk(`OSG_ADDR_IRQ_MSK, 16'h0003);
        rchk(`OSG_ADDR_CMD, 16'h0000);
        s_axi_wstrb <= 4'h2;
        wr(`OSG_ADDR_ENABLE, 16'h5aa5, `OSG_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rchk(`OSG_ADDR_ENABLE, 16'h5a00);
        fork
            rd(`OSG_ADDR_EVENT);
            begin
                @(posedge aclk);
                cond_in <= 16'h0007;
            end
        join
        `CHK({rr, rv}, {`OSG_RESP_OKAY, 32'h0})
        rchk(`OSG_ADDR_EVENT, ev_exp(`OSG_PTR_PRESET, `OSG_NTR_PRESET, 16'h0003, 16'h0007));
        $display("test commands done");
        close_out;
    end
endmodule // operation_status_group_bench

bind osg_core osg_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cond_in,
    .inst_reset, .oper_summary);

/* File: tb/osg_monitor.sv */
// Purpose: port assertions of osg_core
// Assumes: one clock, sync active-low reset
// Notes:   bound from the bench top
`timescale 1ns/1ps
`include "osg_defs.vh"
module osg_monitor (
    input wire                  aclk,
    input wire                  aresetn,
    input wire [`OSG_AW-1:0]    s_axi_awaddr,
    input wire                  s_axi_awvalid,
    input wire                  s_axi_awready,
    input wire [31:0]           s_axi_wdata,
    input wire [3:0]            s_axi_wstrb,
    input wire                  s_axi_wvalid,
    input wire                  s_axi_wready,
    input wire [1:0]            s_axi_bresp,
    input wire                  s_axi_bvalid,
    input wire                  s_axi_bready,
    input wire [`OSG_AW-1:0]    s_axi_araddr,
    input wire                  s_axi_arvalid,
    input wire                  s_axi_arready,
    input wire [31:0]           s_axi_rdata,
    input wire [1:0]            s_axi_rresp,
    input wire                  s_axi_rvalid,
    input wire                  s_axi_rready,
    input wire [`OSG_WIDTH-1:0] cond_in,
    input wire                  inst_reset,
    input wire                  oper_summary
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // command writes
    // ----
    wire cmd_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                  && s_axi_awaddr == `OSG_ADDR_CMD && s_axi_wstrb[0];
    wire rd_go  = s_axi_arvalid && s_axi_arready;
    sequence rst_wr;
        cmd_go && s_axi_wdata[`OSG_CMD_RST_BIT];
    endsequence
    sequence pre_wr;
        cmd_go && s_axi_wdata[`OSG_CMD_PRE_BIT];
    endsequence
    // ----
    // assertions
    // ----
    cond_read_a: assert property (
        rd_go && s_axi_araddr == `OSG_ADDR_COND && $stable(cond_in) |=> s_axi_rdata[15:0] == $past(cond_in))
        else $error("condition read differs from live inputs");
    upper_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("read data above bit 15 not zero");
    rst_pulse_a: assert property (
        rst_wr |-> ##[1:3] inst_reset) else $error("no reset pulse after reset command");
    rst_once_a: assert property (
        inst_reset |=> !inst_reset) else $error("reset pulse longer than one cycle");
    preset_sum_a: assert property (
        pre_wr |-> ##3 !oper_summary) else $error("summary high after preset");
    rd_lat_a: assert property (
        rd_go |=> s_axi_rvalid) else $error("read answer late");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    wr_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    bad_read_a: assert property (
        rd_go && s_axi_araddr >= 8'h20 |=> s_axi_rresp == `OSG_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // osg_monitor
